/* hdl/iscx_pkg.sv */
// Package of constants and types for the increment-skip and subroutine-call execution block
`default_nettype none
package iscx_pkg;
  // Word and address widths
  localparam int unsigned WORD_W   = 12;
  localparam int unsigned OFFS_W   = 7;
  localparam int unsigned PAGE_W   = 5;
  // Operation codes in the top three bits
  localparam logic [2:0]  OP_INC_SKIP = 3'h2;
  localparam logic [2:0]  OP_CALL     = 3'h4;
  // Field positions (bit 11 of the word is the most significant bit)
  localparam int unsigned OPC_MSB  = 11;
  localparam int unsigned OPC_LSB  = 9;
  localparam int unsigned IND_POS  = 8;
  localparam int unsigned PAGE_POS = 7;
  localparam int unsigned OFFS_MSB = 6;
  // Reset values and constant steps
  localparam logic [11:0] WORD_RST = 12'h000;
  localparam logic [11:0] ONE_W    = 12'h001;
  localparam logic [1:0]  CNT_RST  = 2'h0;
  localparam logic [1:0]  CNT_ONE  = 2'h1;

  // Decoded instruction word
  typedef struct packed {
    logic [2:0]  opc;
    logic        ind;
    logic        cur_page;
    logic [6:0]  offs;
  } iscx_instr_s;

  // Memory request carried to the core memory
  typedef struct packed {
    logic        req;
    logic        we;
    logic [11:0] addr;
    logic [11:0] wdata;
  } iscx_mem_req_s;

  // Control states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RD    = 3'b001,
    ST_WR    = 3'b011,
    ST_DONE  = 3'b010,
    ST_DEFER = 3'b100
  } iscx_state_e;
endpackage
`default_nettype wire

/* hdl/iscx_ea.sv */
// Direct operand address former: page zero or current page plus offset
`default_nettype none
module iscx_ea (
  input  wire logic [11:0]         instr_addr, // Address of the instruction itself
  input  wire iscx_pkg::iscx_instr_s instr,    // Decoded instruction word
  output logic [11:0]              ea          // Direct operand address
);
  // Bit 7 clear selects page zero, set selects the instruction's page
  always_comb begin
    ea = {(instr.cur_page ? instr_addr[11:7] : 5'h00), instr.offs};
  end
endmodule
`default_nettype wire

/* hdl/iscx_exec.sv */
// Execution engine for increment-and-skip-if-zero and subroutine-call instructions
`default_nettype none
module iscx_exec (
  input  wire logic                    core_clk,   // System clock, 200 MHz
  input  wire logic                    srst,       // Synchronous reset, active high
  input  wire logic                    start,      // One-cycle request to execute instr
  input  wire logic [11:0]             instr_word, // Instruction word from the buffer
  input  wire logic [11:0]             instr_addr, // Address the instruction was fetched from
  input  wire logic [11:0]             main_working_register_in, // Main working register value
  input  wire logic                    link_in,    // Link bit value
  output iscx_pkg::iscx_mem_req_s      mem_o,      // Memory request, address and write data
  input  wire logic                    mem_ack,    // Memory completes the current access
  input  wire logic [11:0]             mem_rdata,  // Read data, valid with mem_ack on reads
  output logic                         busy,       // Instruction in progress
  output logic                         done,       // One-cycle end of instruction
  output logic [11:0]                  next_instruction_pointer, // Updated program pointer
  output logic                         skip,       // Last increment hit zero
  output logic [11:0]                  main_working_register,    // Working register, returned unchanged
  output logic                         link_out    // Link bit, returned unchanged
);
  iscx_pkg::iscx_state_e state_q, state_d;
  iscx_pkg::iscx_instr_s ins_q, ins_d, ins_in;
  logic [11:0] addr_q, addr_d, wdat_q, wdat_d, nip_q, nip_d, wreg_q, wreg_d, ea_dir;
  logic        skip_q, skip_d, link_q, link_d, op_ok, is_inc;
  logic [1:0]  cyc_q, cyc_d;

  // Field split of the incoming word
  assign ins_in = iscx_pkg::iscx_instr_s'(instr_word);
  assign op_ok  = (ins_in.opc == iscx_pkg::OP_INC_SKIP) || (ins_in.opc == iscx_pkg::OP_CALL);
  assign is_inc = (ins_q.opc == iscx_pkg::OP_INC_SKIP);

  // Direct operand address from the page bit and the offset
  iscx_ea u_ea (
    .instr_addr (instr_addr),
    .instr      (ins_in),
    .ea         (ea_dir)
  );

  // Next-state and datapath computation
  always_comb begin
    state_d = state_q;
    ins_d   = ins_q;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    nip_d   = nip_q;
    wreg_d  = wreg_q;
    link_d  = link_q;
    skip_d  = skip_q;
    cyc_d   = cyc_q;
    case (state_q)
      iscx_pkg::ST_IDLE: begin
        if (start && op_ok) begin
          ins_d  = ins_in;
          addr_d = ea_dir;
          nip_d  = instr_addr + iscx_pkg::ONE_W;
          wdat_d = instr_addr + iscx_pkg::ONE_W;
          wreg_d = main_working_register_in;
          link_d = link_in;
          skip_d = 1'b0;
          cyc_d  = iscx_pkg::CNT_RST;
          // Pointer fetch first when indirect, else straight to the operand access
          if (ins_in.ind) begin
            state_d = iscx_pkg::ST_DEFER;
          end else if (ins_in.opc == iscx_pkg::OP_INC_SKIP) begin
            state_d = iscx_pkg::ST_RD;
          end else begin
            state_d = iscx_pkg::ST_WR;
          end
        end
      end
      iscx_pkg::ST_DEFER: begin
        // Pointer word becomes the effective address
        if (mem_ack) begin
          addr_d  = mem_rdata;
          cyc_d   = cyc_q + iscx_pkg::CNT_ONE;
          state_d = is_inc ? iscx_pkg::ST_RD : iscx_pkg::ST_WR;
        end
      end
      iscx_pkg::ST_RD: begin
        if (mem_ack) begin
          wdat_d  = mem_rdata + iscx_pkg::ONE_W;
          state_d = iscx_pkg::ST_WR;
        end
      end
      iscx_pkg::ST_WR: begin
        if (mem_ack) begin
          cyc_d = cyc_q + iscx_pkg::CNT_ONE;
          // Skip decision uses the value just written, never the old word
          if (is_inc) begin
            skip_d = (wdat_q == iscx_pkg::WORD_RST);
            nip_d  = nip_q + {11'h000, skip_d};
          end else begin
            nip_d = addr_q + iscx_pkg::ONE_W;
          end
          state_d = iscx_pkg::ST_DONE;
        end
      end
      iscx_pkg::ST_DONE: begin
        state_d = iscx_pkg::ST_IDLE;
      end
      default: begin
        state_d = iscx_pkg::ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= iscx_pkg::ST_IDLE;
      ins_q   <= iscx_pkg::iscx_instr_s'(iscx_pkg::WORD_RST);
      addr_q  <= iscx_pkg::WORD_RST;
      wdat_q  <= iscx_pkg::WORD_RST;
      nip_q   <= iscx_pkg::WORD_RST;
      wreg_q  <= iscx_pkg::WORD_RST;
      link_q  <= 1'b0;
      skip_q  <= 1'b0;
      cyc_q   <= iscx_pkg::CNT_RST;
    end else begin
      state_q <= state_d;
      ins_q   <= ins_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      nip_q   <= nip_d;
      wreg_q  <= wreg_d;
      link_q  <= link_d;
      skip_q  <= skip_d;
      cyc_q   <= cyc_d;
    end
  end

  // Memory request and status outputs
  assign mem_o.req   = (state_q == iscx_pkg::ST_DEFER) || (state_q == iscx_pkg::ST_RD) ||
                       (state_q == iscx_pkg::ST_WR);
  assign mem_o.we    = (state_q == iscx_pkg::ST_WR);
  assign mem_o.addr  = addr_q;
  assign mem_o.wdata = wdat_q;
  assign busy        = (state_q != iscx_pkg::ST_IDLE);
  assign done        = (state_q == iscx_pkg::ST_DONE);
  assign next_instruction_pointer = nip_q;
  assign skip                  = skip_q;
  assign main_working_register = wreg_q;
  assign link_out              = link_q;

  // Checks on the increment path (new value, write-back, skip decision) and on every request holding until acknowledged
  AST_INC_VALUE: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == iscx_pkg::ST_RD) && mem_ack |=> mem_o.we && (mem_o.wdata == 12'($past(mem_rdata) + 12'h001)))
    else $error("Write-back value is not read value plus one");
  AST_SKIP_ZERO: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == iscx_pkg::ST_WR) && mem_ack && is_inc && (wdat_q == 12'h000)
      |=> done && skip && (next_instruction_pointer == 12'($past(nip_q) + 12'h001)))
    else $error("Zero result did not skip");
  AST_NO_SKIP: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == iscx_pkg::ST_WR) && mem_ack && is_inc && (wdat_q != 12'h000)
      |=> !skip && $stable(next_instruction_pointer))
    else $error("Nonzero result skipped");
  AST_WB_SAME: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == iscx_pkg::ST_RD) && mem_ack |=> mem_o.req && mem_o.we && $stable(mem_o.addr))
    else $error("Write-back not to the location read");
  AST_REQ_STANDS: assert property (@(posedge core_clk) disable iff (srst)
    mem_o.req && !mem_ack
      |=> mem_o.req && $stable(mem_o.we) && $stable(mem_o.addr) && $stable(mem_o.wdata))
    else $error("Memory request changed before it was acknowledged");
  // The write-back may wait on the memory, so the skip is looked for at the end
  AST_WRAP: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == iscx_pkg::ST_RD) && mem_ack && (mem_rdata == 12'hfff)
      |=> (wdat_q == 12'h000) ##[1:8] (done && skip))
    else $error("All-ones word did not wrap to a skip");
  // Checks on the registers handed back unchanged
  AST_WREG_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    busy && !$past(state_q == iscx_pkg::ST_IDLE) |-> $stable(main_working_register) && $stable(link_out))
    else $error("Working register or link changed during execution");
  // Checks on the subroutine call
  AST_CALL_NO_READ: assert property (@(posedge core_clk) disable iff (srst)
    mem_o.req && !mem_o.we && !is_inc |-> (state_q == iscx_pkg::ST_DEFER))
    else $error("Call read its operand instead of writing the return pointer");
  AST_RET_PTR: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == iscx_pkg::ST_WR) && !is_inc |-> mem_o.we && (mem_o.wdata == nip_q))
    else $error("Return pointer is not call address plus one");
  AST_CALL_DEST: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == iscx_pkg::ST_WR) && mem_ack && !is_inc
      |=> done && (next_instruction_pointer == 12'($past(mem_o.addr) + 12'h001)))
    else $error("Call did not continue at effective address plus one");
  AST_CALL_NO_SKIP: assert property (@(posedge core_clk) disable iff (srst)
    done && !is_inc |-> !skip)
    else $error("Call reported a skip");
  // Checks on sequencing, decode and indirection
  AST_CYCLES: assert property (@(posedge core_clk) disable iff (srst)
    done |-> (cyc_q == (ins_q.ind ? 2'h2 : 2'h1)))
    else $error("Wrong number of memory cycles");
  AST_DONE_PULSE: assert property (@(posedge core_clk) disable iff (srst)
    done |=> !done && !busy)
    else $error("End of instruction lasted more than one cycle");
  AST_DECODE: assert property (@(posedge core_clk) disable iff (srst)
    !busy && start |=> (busy == $past(op_ok)))
    else $error("Opcode decode accepted the wrong instruction");
  AST_DEFER_PTR: assert property (@(posedge core_clk) disable iff (srst)
    (state_q == iscx_pkg::ST_DEFER) && mem_ack |=> (mem_o.addr == $past(mem_rdata)))
    else $error("Pointer word not used as effective address");
  // Scenarios worth seeing at least once
  COV_INC_SKIP:   cover property (@(posedge core_clk) disable iff (srst) done && is_inc && skip);
  COV_INC_NOSKIP: cover property (@(posedge core_clk) disable iff (srst) done && is_inc && !skip);
  COV_INC_IND:    cover property (@(posedge core_clk) disable iff (srst) done && is_inc && ins_q.ind);
  COV_CALL_DIR:   cover property (@(posedge core_clk) disable iff (srst) done && !is_inc && !ins_q.ind);
  COV_CALL_IND:   cover property (@(posedge core_clk) disable iff (srst) done && !is_inc && ins_q.ind);
endmodule
`default_nettype wire

/* dv/iscx_mem_model.sv */
// Core memory partner model with an adjustable acknowledge delay
`default_nettype none
module iscx_mem_model (
  input  wire logic                    core_clk,  // System clock
  input  wire logic                    srst,      // Synchronous reset, active high
  input  wire iscx_pkg::iscx_mem_req_s mem_i,     // Request from the block
  input  wire logic [1:0]              lat,       // Wait cycles before acknowledge
  output logic                         mem_ack,   // Access completes
  output logic                         mem_rdata_v, // Read data valid beside a read acknowledge
  output logic [11:0]                  mem_rdata  // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] words [4096];
  logic [1:0]  wait_q;
  logic [11:0] last_q;
  // Acknowledge once the wait count reaches the chosen delay
  assign mem_ack     = mem_i.req && (wait_q == lat);
  assign mem_rdata_v = mem_ack && !mem_i.we;
  // Data only beside a read acknowledge; otherwise the inverse of the last value
  assign mem_rdata   = (mem_ack && !mem_i.we) ? words[mem_i.addr] : ~last_q;
  // Count waits and store writes; a plain always since the bench preloads words
  always @(posedge core_clk) begin
    if (srst) begin
      wait_q <= 2'h0;
    end else begin
      wait_q <= (mem_i.req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
      if (mem_ack && mem_i.we) begin
        words[mem_i.addr] <= mem_i.wdata;
      end
    end
    last_q <= mem_rdata;
  end
endmodule
`default_nettype wire

/* dv/increment_skip_and_call_exec_bench.sv */
// Self-checking bench for the increment-skip and subroutine-call block
`default_nettype none
module increment_skip_and_call_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, srst = 1'b1, start = 1'b0, link_in = 1'b0, mem_ack, busy, done, skip, link_out, rv;
  logic [11:0] instr_word = 12'h000, instr_addr = 12'h000, mwr_in = 12'h000;
  logic [11:0] mem_rdata, nip, mwr;
  logic [1:0]  lat = 2'h0;
  iscx_pkg::iscx_mem_req_s mem_o;
  int bad_count = 0, n_checks = 0, acks = 0, rds = 0;
  int sh [4096];
  // Half period of 2.5 ns gives 200 MHz
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (mem_o.req === 1'b1 && mem_ack === 1'b1) acks++;
  // Reads completed, counted from the memory's own read-valid marker
  always @(posedge core_clk) if (rv === 1'b1) rds++;
  iscx_exec dut (.core_clk(core_clk), .srst(srst), .start(start), .instr_word(instr_word),
    .instr_addr(instr_addr), .main_working_register_in(mwr_in), .link_in(link_in), .mem_o(mem_o),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .busy(busy), .done(done), .next_instruction_pointer(nip), .skip(skip),
    .main_working_register(mwr), .link_out(link_out));
  iscx_mem_model mm (.core_clk(core_clk), .srst(srst), .mem_i(mem_o), .lat(lat), .mem_ack(mem_ack),
    .mem_rdata_v(rv), .mem_rdata(mem_rdata));
  // Compare one value and count it
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Print counts and the verdict, then stop
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Run one instruction and compare against the integer model
  task automatic run(input logic [11:0] iw, input logic [11:0] ia, input logic [11:0] pv);
    int ea, loc, v, ptr, sk, nacc, n, nrd;
    loc = (iw[7] ? (int'(ia) / 128) * 128 : 0) + int'(iw[6:0]);
    sh[loc] = int'(pv);
    mm.words[loc] = pv;
    ea = iw[8] ? sh[loc] : loc;
    nacc = iw[8] ? 2 : 1;
    nrd = iw[8] ? 1 : 0;
    if (iw[11:9] == 3'h2) begin
      v = (sh[ea] + 1) % 4096;
      sh[ea] = v;
      sk = (v == 0);
      ptr = (int'(ia) + 1 + sk) % 4096;
      nacc++;
      nrd++;
    end else begin
      sh[ea] = (int'(ia) + 1) % 4096;
      sk = 0;
      ptr = (ea + 1) % 4096;
    end
    @(posedge core_clk);
    lat <= 2'($urandom_range(0, 3));
    instr_word <= iw;
    instr_addr <= ia;
    mwr_in <= 12'($urandom);
    link_in <= 1'($urandom);
    start <= 1'b1;
    acks = 0;
    rds = 0;
    @(posedge core_clk);
    start <= 1'b0;
    for (n = 0; n < 100 && done !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    if (n == 100) begin
      bad_count++;
      $display("test iw %h at %h timed out", iw, ia);
      return;
    end
    check("pointer", nip, 12'(ptr));
    check("skip", {11'h000, skip}, 12'(sk));
    check("word", mm.words[ea], 12'(sh[ea]));
    check("accesses", 12'(acks), 12'(nacc));
    check("reads", 12'(rds), 12'(nrd));
    check("working", mwr, mwr_in);
    check("link", {11'h000, link_out}, {11'h000, link_in});
    @(posedge core_clk);
    $display("test iw %h at %h done", iw, ia);
  endtask
  initial begin
    logic [11:0] w;
    void'($urandom(37327));
    for (int i = 0; i < 4096; i++) begin
      sh[i] = int'($urandom_range(0, 4095));
      mm.words[i] = 12'(sh[i]);
    end
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    run(12'o2250, 12'o0201, 12'o7777);
    run(12'o2250, 12'o7776, 12'o7777);
    run(12'o2250, 12'o0201, 12'o7776);
    run(12'o4350, 12'o7777, 12'o0000);
    run(12'o4650, 12'o4600, 12'o1234);
    // Refused opcode leaves the block idle
    @(posedge core_clk);
    instr_word <= 12'o5250;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    check("busy", {11'h000, busy}, 12'h000);
    $display("test refused opcode done");
    for (int t = 0; t < 40; t++) begin
      w = 12'($urandom);
      w[11:9] = ($urandom_range(0, 1) == 1) ? 3'h2 : 3'h4;
      run(w, 12'($urandom), 12'($urandom));
    end
    summarize();
  end
endmodule
`default_nettype wire
